// file: src/wcs_consts.vh
// How it works
// - each wake input has two pull bits: none, pull-down, pull-up, automatic
// - filter codes 00 and 01 give static sensing with 16 us or 64 us filter
// - filter codes 10 and 11 sample 16 us at end of timer one or two on-time
// - on-time codes 001 to 101 give 0.1, 0.3, 1, 10, 20 ms; 111 reserved
// - on-time 000 stops timer with output low; 110 stops it with output high
// - period codes 000 to 110 give 10 ms to 2 s; 111 reserved
// - once assigned to an output, timer starts when a running on-time is written
// - timer one cyclic sensing (code 10) with switches cleared by the clear bit also clears timer fields
// - timer wake and cyclic sensing run together when both are enabled
// - restart clears upper two bits of pull and filter registers, keeps the rest
// - restart clears timer control; power-on or soft reset clears all three
// - unused register bits always read back as zero
// - timer wake enable bit makes timer one a cyclic wake source
`ifndef WCS_CONSTS_VH
`define WCS_CONSTS_VH
// register indices: the byte address on the bus is four times the index
`define WCS_OFF_PULL 8'h08
`define WCS_OFF_FILT 8'h09
`define WCS_OFF_TMR 8'h0C
`define WCS_OFF_CTRL 8'h10
`define WCS_OFF_STAT 8'h14
`define WCS_RST_REG 8'h00
`define WCS_CFG_MASK 8'h3F
`define WCS_TMR_MASK 8'h77
`define WCS_ON_LSB 4
`define WCS_CTRL_WAKE_EN 0
`define WCS_CTRL_HS_ASSIGN 1
`define WCS_CTRL_RESTART 2
`define WCS_CTRL_HS_CLEAR 3
`define WCS_CTRL_SOFT_RST 4
`define WCS_CLK_MHZ 100
`define WCS_FILT_SHORT_US 16
`define WCS_FILT_LONG_US 64
`define WCS_FILT_SHORT_CYC (`WCS_FILT_SHORT_US * `WCS_CLK_MHZ)
`define WCS_FILT_LONG_CYC (`WCS_FILT_LONG_US * `WCS_CLK_MHZ)
`define WCS_CYC_PER_US 100
`define WCS_ON_0_1MS_US 100
`define WCS_ON_0_3MS_US 300
`define WCS_ON_1MS_US 1000
`define WCS_ON_10MS_US 10000
`define WCS_ON_20MS_US 20000
`define WCS_PER_10MS_US 10000
`define WCS_PER_20MS_US 20000
`define WCS_PER_50MS_US 50000
`define WCS_PER_100MS_US 100000
`define WCS_PER_200MS_US 200000
`define WCS_PER_1S_US 1000000
`define WCS_PER_2S_US 2000000
`endif

// file: src/wcs_us_tick.v
`timescale 1ns/10ps
`include "wcs_consts.vh"
// one-cycle pulse every microsecond, the time base of the cyclic timer
module wcs_us_tick (
   input wire clk_in,
   input wire rst_in,
   output reg tick_out
);
   reg [6:0] count;
   localparam [6:0] TICK_LAST = `WCS_CYC_PER_US - 1;
   always @(posedge clk_in) begin
      if (rst_in) begin
         count <= 7'h00;
         tick_out <= 1'b0;
      end else if (count == TICK_LAST) begin
         count <= 7'h00;
         tick_out <= 1'b1;
      end else begin
         count <= count + 7'h01;
         tick_out <= 1'b0;
      end
   end
endmodule // wcs_us_tick

// file: src/wcs_wake_filter.v
`timescale 1ns/10ps
`include "wcs_consts.vh"
// per-input filter: static (continuous) or cyclic (window at end of on-time)
module wcs_wake_filter (
   input wire clk_in,
   input wire rst_in,
   input wire level_in,
   input wire [1:0] mode_in,
   input wire window_one_in,
   input wire window_two_in,
   output reg state_out
);
   reg [12:0] count;
   reg [12:0] limit;
   reg active;
   localparam [12:0] LIM_SHORT = `WCS_FILT_SHORT_CYC;
   localparam [12:0] LIM_LONG = `WCS_FILT_LONG_CYC;
   always @* begin
      case (mode_in)
         2'b00: begin
            limit = LIM_SHORT;
            active = 1'b1;
         end
         2'b01: begin
            limit = LIM_LONG;
            active = 1'b1;
         end
         2'b10: begin
            limit = LIM_SHORT;
            active = window_one_in;
         end
         default: begin
            limit = LIM_SHORT;
            active = window_two_in;
         end
      endcase
   end
   // a level differing from the held state must persist for the whole limit
   always @(posedge clk_in) begin
      if (rst_in) begin
         count <= 13'h0000;
         state_out <= 1'b0;
      end else if (!active || level_in == state_out) begin
         count <= 13'h0000;
      end else if (count >= limit - 13'h0001) begin
         count <= 13'h0000;
         state_out <= level_in;
      end else begin
         count <= count + 13'h0001;
      end
   end
endmodule // wcs_wake_filter

// file: src/wcs_top.v
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "wcs_consts.vh"
module wcs_top (
   input wire clk_in,
   input wire rst_in,
   input wire [31:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [31:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire [2:0] wake_level_in,
   input wire timer_two_window_in,
   output reg [2:0] pull_up_out,
   output reg [2:0] pull_down_out,
   output reg [2:0] pull_auto_out,
   output reg [2:0] wake_state_out,
   output reg high_side_output,
   output reg timer_one_window_out,
   output reg timer_one_wake_out,
   output reg timer_one_running_out
);
   localparam ST_IDLE = 3'b001;
   localparam ST_ON = 3'b010;
   localparam ST_OFF = 3'b100;
   // limits in microseconds, sized once at the timer width
   localparam [20:0] ON_T1 = `WCS_ON_0_1MS_US;
   localparam [20:0] ON_T2 = `WCS_ON_0_3MS_US;
   localparam [20:0] ON_T3 = `WCS_ON_1MS_US;
   localparam [20:0] ON_T4 = `WCS_ON_10MS_US;
   localparam [20:0] ON_T5 = `WCS_ON_20MS_US;
   localparam [20:0] PER_T0 = `WCS_PER_10MS_US;
   localparam [20:0] PER_T1 = `WCS_PER_20MS_US;
   localparam [20:0] PER_T2 = `WCS_PER_50MS_US;
   localparam [20:0] PER_T3 = `WCS_PER_100MS_US;
   localparam [20:0] PER_T4 = `WCS_PER_200MS_US;
   localparam [20:0] PER_T5 = `WCS_PER_1S_US;
   localparam [20:0] PER_T6 = `WCS_PER_2S_US;
   localparam [20:0] WIN_US = `WCS_FILT_SHORT_US;

   reg [7:0] wake_pull_config;
   reg [7:0] wake_filter_config;
   reg [7:0] cyclic_timer_one_control;
   reg [1:0] ctrl_bits;
   reg soft_reset;
   reg [2:0] state;
   reg [20:0] time_us;
   reg [20:0] on_limit;
   reg [20:0] per_limit;
   reg [31:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   reg aw_held;
   reg w_held;
   reg [2:0] wake_s1;
   reg [2:0] wake_s2;
   reg win2_s1;
   reg win2_s2;
   reg [31:0] next_rdata;
   wire us_tick;
   wire [2:0] filt_state;
   wire [2:0] timer_one_on_time;
   wire [2:0] timer_one_period;
   wire timer_one_wake_enable;
   wire hs_assigned;
   wire any_cyclic_one;
   wire wr_fire;
   wire [31:0] wr_addr;
   wire [31:0] wr_dat;
   wire [3:0] wr_be;
   wire ctrl_wr;
   wire restart_pulse;
   wire hs_clear_pulse;
   wire on_running;
   wire tmr_wr;
   wire clr_all;

   assign timer_one_on_time = cyclic_timer_one_control[6:4];
   assign timer_one_period = cyclic_timer_one_control[2:0];
   assign timer_one_wake_enable = ctrl_bits[`WCS_CTRL_WAKE_EN];
   assign hs_assigned = ctrl_bits[`WCS_CTRL_HS_ASSIGN];
   assign clr_all = rst_in | soft_reset;

   // write channel: address and data may arrive in either order
   assign wr_addr = aw_held ? aw_addr : s_axi_awaddr;
   assign wr_dat = w_held ? w_data : s_axi_wdata;
   assign wr_be = w_held ? w_strb : s_axi_wstrb;
   assign wr_fire = (aw_held | s_axi_awvalid) & (w_held | s_axi_wvalid) & ~s_axi_bvalid;
   assign ctrl_wr = wr_fire & wr_be[0] & (wr_addr[9:2] == `WCS_OFF_CTRL);
   assign restart_pulse = ctrl_wr & wr_dat[`WCS_CTRL_RESTART];
   assign hs_clear_pulse = ctrl_wr & wr_dat[`WCS_CTRL_HS_CLEAR];
   assign tmr_wr = wr_fire & wr_be[0] & (wr_addr[9:2] == `WCS_OFF_TMR);

   always @(posedge clk_in) begin
      if (rst_in) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 32'h00000000;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end else begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (wr_fire) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= 2'b00;
            s_axi_awready <= ~aw_held;
            s_axi_wready <= ~w_held;
         end else begin
            if (s_axi_awvalid & ~aw_held & ~s_axi_awready) begin
               aw_held <= 1'b1;
               aw_addr <= s_axi_awaddr;
               s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid & ~w_held & ~s_axi_wready) begin
               w_held <= 1'b1;
               w_data <= s_axi_wdata;
               w_strb <= s_axi_wstrb;
               s_axi_wready <= 1'b1;
            end
         end
      end
   end

   // registers; restart keeps lower six bits of the config registers
   always @(posedge clk_in) begin
      if (clr_all) begin
         wake_pull_config <= `WCS_RST_REG;
         wake_filter_config <= `WCS_RST_REG;
         cyclic_timer_one_control <= `WCS_RST_REG;
         ctrl_bits <= 2'b00;
         soft_reset <= 1'b0;
      end else if (restart_pulse) begin
         wake_pull_config <= wake_pull_config & `WCS_CFG_MASK;
         wake_filter_config <= wake_filter_config & `WCS_CFG_MASK;
         cyclic_timer_one_control <= `WCS_RST_REG;
         soft_reset <= 1'b0;
      end else begin
         soft_reset <= ctrl_wr & wr_dat[`WCS_CTRL_SOFT_RST];
         if (hs_clear_pulse) begin
            ctrl_bits[`WCS_CTRL_HS_ASSIGN] <= 1'b0;
            if (any_cyclic_one) begin
               cyclic_timer_one_control <= `WCS_RST_REG;
            end
         end else if (tmr_wr) begin
            cyclic_timer_one_control <= wr_dat[7:0] & `WCS_TMR_MASK;
         end
         if (wr_fire & wr_be[0]) begin
            if (wr_addr[9:2] == `WCS_OFF_PULL) begin
               wake_pull_config <= wr_dat[7:0] & `WCS_CFG_MASK;
            end
            if (wr_addr[9:2] == `WCS_OFF_FILT) begin
               wake_filter_config <= wr_dat[7:0] & `WCS_CFG_MASK;
            end
            if (ctrl_wr & ~hs_clear_pulse) begin
               ctrl_bits <= wr_dat[1:0];
            end
         end
      end
   end

   // read channel
   always @* begin
      case (s_axi_araddr[9:2])
         `WCS_OFF_PULL: next_rdata = {24'h000000, wake_pull_config};
         `WCS_OFF_FILT: next_rdata = {24'h000000, wake_filter_config};
         `WCS_OFF_TMR: next_rdata = {24'h000000, cyclic_timer_one_control};
         `WCS_OFF_CTRL: next_rdata = {30'h00000000, ctrl_bits};
         `WCS_OFF_STAT: next_rdata = {26'h0000000, high_side_output, timer_one_running_out, 1'b0, wake_state_out};
         default: next_rdata = 32'h00000000;
      endcase
   end

   always @(posedge clk_in) begin
      if (rst_in) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'b00;
      end else begin
         s_axi_arready <= 1'b0;
         if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end else if (s_axi_arvalid & ~s_axi_rvalid & ~s_axi_arready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= 2'b00;
         end
      end
   end

   // time tables in microseconds
   always @* begin
      case (timer_one_on_time)
         3'h1: on_limit = ON_T1;
         3'h2: on_limit = ON_T2;
         3'h3: on_limit = ON_T3;
         3'h4: on_limit = ON_T4;
         3'h5: on_limit = ON_T5;
         default: on_limit = 21'h000000;
      endcase
      case (timer_one_period)
         3'h0: per_limit = PER_T0;
         3'h1: per_limit = PER_T1;
         3'h2: per_limit = PER_T2;
         3'h3: per_limit = PER_T3;
         3'h4: per_limit = PER_T4;
         3'h5: per_limit = PER_T5;
         3'h6: per_limit = PER_T6;
         default: per_limit = 21'h000000;
      endcase
   end

   // reserved period code 111 keeps the timer idle rather than guessing a period
   assign on_running = (on_limit != 21'h000000) & (per_limit != 21'h000000) & hs_assigned;

   wcs_us_tick u_tick (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .tick_out(us_tick)
   );

   always @(posedge clk_in) begin
      if (rst_in) begin
         state <= ST_IDLE;
         time_us <= 21'h000000;
         high_side_output <= 1'b0;
         timer_one_window_out <= 1'b0;
         timer_one_wake_out <= 1'b0;
         timer_one_running_out <= 1'b0;
      end else begin
         timer_one_running_out <= on_running;
         case (state)
            ST_IDLE: begin
               time_us <= 21'h000000;
               timer_one_window_out <= 1'b0;
               timer_one_wake_out <= 1'b0;
               high_side_output <= (timer_one_on_time == 3'h6);
               if (on_running) begin
                  state <= ST_ON;
                  high_side_output <= 1'b1;
               end
            end
            ST_ON: begin
               timer_one_wake_out <= 1'b0;
               if (!on_running) begin
                  state <= ST_IDLE;
               end else if (us_tick) begin
                  time_us <= time_us + 21'h000001;
                  // sense window: last 16 us of the on-time
                  timer_one_window_out <= (time_us + WIN_US + 21'h000001 >= on_limit);
                  if (time_us + 21'h000001 >= on_limit) begin
                     state <= ST_OFF;
                     high_side_output <= 1'b0;
                     timer_one_window_out <= 1'b0;
                     timer_one_wake_out <= timer_one_wake_enable;
                  end
               end
            end
            ST_OFF: begin
               timer_one_wake_out <= 1'b0;
               if (!on_running) begin
                  state <= ST_IDLE;
               end else if (us_tick) begin
                  time_us <= time_us + 21'h000001;
                  if (time_us + 21'h000001 >= per_limit) begin
                     state <= ST_ON;
                     time_us <= 21'h000000;
                     high_side_output <= 1'b1;
                  end
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   always @(posedge clk_in) begin
      if (rst_in) begin
         wake_s1 <= 3'h0;
         wake_s2 <= 3'h0;
         win2_s1 <= 1'b0;
         win2_s2 <= 1'b0;
      end else begin
         wake_s1 <= wake_level_in;
         wake_s2 <= wake_s1;
         win2_s1 <= timer_two_window_in;
         win2_s2 <= win2_s1;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_in
         wcs_wake_filter u_filt (
            .clk_in(clk_in),
            .rst_in(rst_in),
            .level_in(wake_s2[gi]),
            .mode_in(wake_filter_config[2*gi+1:2*gi]),
            .window_one_in(timer_one_window_out),
            .window_two_in(win2_s2),
            .state_out(filt_state[gi])
         );
         always @(posedge clk_in) begin
            if (rst_in) begin
               pull_up_out[gi] <= 1'b0;
               pull_down_out[gi] <= 1'b0;
               pull_auto_out[gi] <= 1'b0;
               wake_state_out[gi] <= 1'b0;
            end else begin
               pull_down_out[gi] <= (wake_pull_config[2*gi+1:2*gi] == 2'b01);
               pull_up_out[gi] <= (wake_pull_config[2*gi+1:2*gi] == 2'b10);
               pull_auto_out[gi] <= (wake_pull_config[2*gi+1:2*gi] == 2'b11);
               wake_state_out[gi] <= filt_state[gi];
            end
         end
      end
   endgenerate

   assign any_cyclic_one = (wake_filter_config[1:0] == 2'b10) | (wake_filter_config[3:2] == 2'b10) |
                           (wake_filter_config[5:4] == 2'b10);
endmodule // wcs_top

// file: dv/wcs_top_assertions.sv
`timescale 1ns/10ps
module wcs_top_assertions (
   input wire clk_in,
   input wire rst_in,
   input wire s_axi_arvalid,
   input wire s_axi_bready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire [2:0] pull_up_out,
   input wire [2:0] pull_down_out,
   input wire [2:0] pull_auto_out,
   input wire high_side_output,
   input wire timer_one_window_out,
   input wire timer_one_wake_out,
   input wire timer_one_running_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   a_reset_clear: assert property ($fell(rst_in) |-> !high_side_output && !timer_one_running_out &&
      pull_up_out == 3'h0 && pull_down_out == 3'h0 && pull_auto_out == 3'h0) else $error("outputs not cleared");
   a_pull_excl: assert property ((pull_up_out & pull_down_out) == 3'h0 && (pull_up_out & pull_auto_out) == 3'h0 &&
      (pull_down_out & pull_auto_out) == 3'h0) else $error("two pull modes at once");
   a_window_in_on: assert property (timer_one_window_out |-> high_side_output) else $error("window outside on-time");
   a_window_len: assert property ($rose(timer_one_window_out) |-> timer_one_window_out[*8])
      else $error("sense window too short");
   a_wake_pulse: assert property (timer_one_wake_out |=> !timer_one_wake_out) else $error("wake pulse too long");
   a_wake_at_end: assert property (timer_one_wake_out |-> timer_one_running_out && (timer_one_window_out ||
      $past(timer_one_window_out) || $past(timer_one_window_out, 2))) else $error("wake not at end of on-time");
   a_run_drives: assert property ($rose(timer_one_running_out) |-> ##[0:2] high_side_output)
      else $error("started timer left output low");
   a_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid) else $error("read not answered");
   a_rdata_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000 && s_axi_rresp == 2'b00)
      else $error("read upper bits or response wrong");
   a_write_done: assert property (s_axi_bvalid && s_axi_bready |-> s_axi_bresp == 2'b00 ##1 !s_axi_bvalid)
      else $error("write response wrong");
   c_window: cover property ($rose(timer_one_window_out));
   c_wake: cover property (timer_one_wake_out);
   c_run: cover property ($rose(timer_one_running_out));
endmodule // wcs_top_assertions

bind wcs_top wcs_top_assertions i_wcs_top_assertions (.clk_in(clk_in), .rst_in(rst_in),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .pull_up_out(pull_up_out), .pull_down_out(pull_down_out), .pull_auto_out(pull_auto_out),
   .high_side_output(high_side_output), .timer_one_window_out(timer_one_window_out),
   .timer_one_wake_out(timer_one_wake_out), .timer_one_running_out(timer_one_running_out));

// file: dv/wcs_switch_model.sv
`timescale 1ns/10ps
// external switches fed from the high-side output, one per wake input
module wcs_switch_model (
   input wire clk_in,
   input wire high_side_in,
   input wire [2:0] closed_in,
   input wire [2:0] pull_up_in,
   input wire [2:0] pull_down_in,
   input wire [2:0] pull_auto_in,
   output reg [2:0] level_out
);
   integer i;
   initial level_out = 3'h0;
   always @(posedge clk_in) begin
      for (i = 0; i < 3; i = i + 1) begin
         if (closed_in[i]) level_out[i] <= high_side_in; // sensed only through the switch supply
         else if (pull_up_in[i]) level_out[i] <= 1'b1;
         else if (pull_down_in[i]) level_out[i] <= 1'b0;
         else if (!pull_auto_in[i]) level_out[i] <= ~level_out[i]; // floating line wanders
      end
   end
endmodule // wcs_switch_model

// file: dv/wcs_top_tb.sv
`timescale 1ns/10ps
module wcs_top_tb;
   reg clk_in = 1'b0;
   reg rst_in = 1'b1;
   reg [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rv = 32'h0;
   reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   reg [2:0] closed = 3'h0;
   reg tmr_two = 1'b0;
   wire awready, wready, bvalid, arready, rvalid, hs, win, wake, run;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [2:0] level, pu, pd, pa, wst;
   integer n_fail = 0, comparisons = 0, hs_n = 0, win_n = 0, wakes = 0, h0, w0, k0, i;
   always #5 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      if (hs === 1'b1) hs_n <= hs_n + 1;
      if (win === 1'b1) win_n <= win_n + 1;
      if (wake === 1'b1) wakes <= wakes + 1;
   end
   wcs_top i_wcs_top (.clk_in(clk_in), .rst_in(rst_in), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .wake_level_in(level),
      .timer_two_window_in(tmr_two), .pull_up_out(pu), .pull_down_out(pd), .pull_auto_out(pa),
      .wake_state_out(wst), .high_side_output(hs), .timer_one_window_out(win), .timer_one_wake_out(wake),
      .timer_one_running_out(run));
   wcs_switch_model i_wcs_switch_model (.clk_in(clk_in), .high_side_in(hs), .closed_in(closed),
      .pull_up_in(pu), .pull_down_in(pd), .pull_auto_in(pa), .level_out(level));
   task stop_test; begin
      $display("mismatches %0d comparisons %0d", n_fail, comparisons);
      if (n_fail == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   end endtask
   task chk(input [31:0] got, input [31:0] exp); begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
         n_fail = n_fail + 1;
         $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
      end
   end endtask
   task rng(input integer v, input integer lo, input integer hi); begin
      chk({31'h0, v >= lo && v <= hi}, 32'h1);
   end endtask
   task cyc(input integer c); begin
      repeat (c) @(posedge clk_in);
   end endtask
   // aw and w are released independently, bready held until the response
   task wr(input [7:0] a, input [7:0] d);
      integer k;
      reg done;
      begin
         @(posedge clk_in);
         awaddr <= {22'h0, a, 2'b00}; // register index in, byte address out
         wdata <= {24'h0, d};
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         done = 1'b0;
         for (k = 0; k < 100 && !done; k = k + 1) begin
            @(posedge clk_in);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
               bready <= 1'b0;
               done = 1'b1;
            end
         end
         if (!done) begin
            chk(32'h0, 32'h1);
            stop_test;
         end
      end
   endtask
   task rc(input [7:0] a, input [7:0] e);
      integer k;
      reg done;
      begin
         @(posedge clk_in);
         araddr <= {22'h0, a, 2'b00};
         arvalid <= 1'b1;
         rready <= 1'b1;
         done = 1'b0;
         for (k = 0; k < 100 && !done; k = k + 1) begin
            @(posedge clk_in);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
               rv = rdata;
               rready <= 1'b0;
               done = 1'b1;
            end
         end
         if (!done) begin
            chk(32'h0, 32'h1);
            stop_test;
         end else begin
            chk(rv, {24'h0, e});
         end
      end
   endtask
   initial begin
      cyc(20);
      rst_in <= 1'b0;
      rc(8'h08, 8'h00);
      rc(8'h09, 8'h00);
      rc(8'h0C, 8'h00);
      wr(8'h08, 8'hFF);
      rc(8'h08, 8'h3F);
      wr(8'h09, 8'hFF);
      rc(8'h09, 8'h3F);
      wr(8'h0C, 8'hFF);
      rc(8'h0C, 8'h77);
      wr(8'h20, 8'h55);
      rc(8'h20, 8'h00);
      wr(8'h08, 8'h27);
      cyc(2);
      chk({23'h0, pu, pd, pa}, {23'h0, 3'b100, 3'b010, 3'b001});
      wr(8'h08, 8'h00);
      cyc(2);
      chk({23'h0, pu, pd, pa}, 32'h0);
      // static filters, switches fed by an output held high
      wr(8'h08, 8'h15);
      wr(8'h0C, 8'h00);
      wr(8'h10, 8'h02);
      wr(8'h0C, 8'h60);
      cyc(2);
      chk({31'h0, hs}, 32'h1);
      wr(8'h09, 8'h04);
      cyc(100);
      closed <= 3'b011;
      cyc(1500);
      chk({29'h0, wst}, 32'h0);
      cyc(300);
      chk({29'h0, wst}, 32'h1);
      cyc(4500);
      chk({29'h0, wst}, 32'h1);
      cyc(300);
      chk({29'h0, wst}, 32'h3);
      // timer two window drives the cyclic filter of input three
      wr(8'h09, 8'h34);
      closed <= 3'b111;
      cyc(1500);
      chk({29'h0, wst}, 32'h3);
      tmr_two <= 1'b1;
      cyc(1500);
      chk({29'h0, wst}, 32'h3);
      cyc(200);
      chk({29'h0, wst}, 32'h7);
      closed <= 3'b011;
      cyc(1700);
      chk({29'h0, wst}, 32'h3);
      tmr_two <= 1'b0;
      wr(8'h0C, 8'h00);
      cyc(2);
      chk({31'h0, hs}, 32'h0);
      // running on-time without an assigned output must not start
      wr(8'h10, 8'h01);
      wr(8'h0C, 8'h10);
      cyc(5);
      chk({30'h0, run, hs}, 32'h0);
      wr(8'h0C, 8'h00);
      wr(8'h09, 8'h20);
      closed <= 3'b100;
      wr(8'h10, 8'h03);
      h0 = hs_n;
      w0 = win_n;
      k0 = wakes;
      wr(8'h0C, 8'h10);
      cyc(5000);
      chk({31'h0, run}, 32'h1);
      chk({29'h0, wst}, 32'h0);
      cyc(7000);
      chk({29'h0, wst}, 32'h4);
      rng(hs_n - h0, 9900, 10100);
      rng(win_n - w0, 1500, 1700);
      chk(wakes - k0, 32'h1);
      rc(8'h14, 8'h14);
      wr(8'h0C, 8'h00);
      wr(8'h10, 8'h02);
      k0 = wakes;
      wr(8'h0C, 8'h10);
      cyc(12000);
      chk(wakes - k0, 32'h0);
      // restart keeps the configuration fields, clears the timer
      wr(8'h08, 8'h2A);
      wr(8'h09, 8'h1B);
      wr(8'h10, 8'h04);
      rc(8'h08, 8'h2A);
      rc(8'h09, 8'h1B);
      rc(8'h0C, 8'h00);
      wr(8'h09, 8'h02);
      wr(8'h10, 8'h02);
      wr(8'h0C, 8'h11);
      wr(8'h10, 8'h08);
      rc(8'h0C, 8'h00);
      wr(8'h09, 8'h00);
      wr(8'h10, 8'h02);
      wr(8'h0C, 8'h21);
      wr(8'h10, 8'h08);
      rc(8'h0C, 8'h21);
      for (i = 0; i < 8; i = i + 1) begin
         wr(8'h0C, {1'b0, i[2:0], 1'b0, i[2:0]});
         rc(8'h0C, {1'b0, i[2:0], 1'b0, i[2:0]});
      end
      wr(8'h08, 8'h15);
      wr(8'h10, 8'h10);
      cyc(2);
      rc(8'h08, 8'h00);
      rc(8'h0C, 8'h00);
      stop_test;
   end
endmodule // wcs_top_tb
